// >>> src/angle_map_pkg.sv
// constants, types and configuration layout of the angle to pwm mapper
// =====================================================================
package angle_map_pkg;
    // =================================================================
    // clock and timing
    localparam int CLK_HZ       = 40000000;
    localparam int CLK_NS       = 25;
    localparam int WDOG_MAX_US  = 12000;
    localparam int WDOG_CYC     = (WDOG_MAX_US * 1000) / CLK_NS;
    localparam int SUP_DET_NS   = 50000;
    localparam int SUP_REC_NS   = 50000;
    localparam logic [11:0] DET_CYC = 12'((SUP_DET_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] REC_CYC = 12'((SUP_REC_NS + CLK_NS - 1) / CLK_NS);
    localparam int PWM_STEPS    = 4096;

    // prescale of one pwm step, rounded to nearest
    function automatic int step_div(input int hz);
        return (CLK_HZ + hz * (PWM_STEPS / 2)) / (hz * PWM_STEPS);
    endfunction

    localparam logic [7:0] PWM_DIV [8] = '{
        8'(step_div(2197)), 8'(step_div(1100)), 8'(step_div(732)),
        8'(step_div(549)),  8'(step_div(366)),  8'(step_div(244)),
        8'(step_div(200)),  8'(step_div(122))};

    // =================================================================
    // duty levels and bus map
    localparam logic [11:0] FAULT_HIGH_DUTY = 12'hfae;
    localparam logic [11:0] FAULT_LOW_DUTY  = 12'h052;
    localparam logic [11:0] ADDR_RANGE  = 12'h000;
    localparam logic [11:0] ADDR_DUTY   = 12'h004;
    localparam logic [11:0] ADDR_CLAMP  = 12'h008;
    localparam logic [11:0] ADDR_MODE   = 12'h00c;
    localparam logic [11:0] ADDR_FUSE   = 12'h010;
    localparam logic [11:0] ADDR_STATUS = 12'h014;
    localparam int FUSE_BITS = 128;

    // =================================================================
    // configuration image, also the layout of the fuse array
    typedef struct packed {
        logic        customer_lock_fuse;
        logic        fault_band_polarity;
        logic [2:0]  frame_rate_select;
        logic [1:0]  slope_count_select;
        logic        slope_invert;
        logic [13:0] wrap_transition_point;
        logic [8:0]  clamp_high_level;
        logic [8:0]  clamp_low_level;
        logic [11:0] stop_duty_level;
        logic [11:0] start_duty_level;
        logic [13:0] angle_stop_point;
        logic [13:0] angle_start_point;
    } cfg_s;

    localparam int SPARE_BITS = FUSE_BITS - $bits(cfg_s);

    typedef enum logic [1:0] {
        SUPPLY_OK = 2'b00,
        SUPPLY_OV = 2'b01,
        SUPPLY_UV = 2'b10
    } supply_e;
endpackage

// >>> src/angle_to_pwm_output_mapper.sv
// angle to pwm output mapper with supply monitor, watchdog and fuses
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps

module angle_to_pwm_output_mapper #(
    parameter int WDOG_CYCLES = angle_map_pkg::WDOG_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // angle path, same clock
    input  wire logic [13:0] angle_code,
    input  wire logic        dsp_alive,
    input  wire logic        mag_range_alarm,
    input  wire logic        cordic_overflow,
    input  wire logic        osc_fail,
    // supply comparators, asynchronous
    input  wire logic        ov_above_high,
    input  wire logic        ov_below_low,
    input  wire logic        uv_below_low,
    input  wire logic        uv_above_high,
    // open-drain output pin
    output logic             pwm_o,
    output logic             pwm_oe
);

    // =================================================================
    // state
    typedef struct packed {
        logic [3:0]             sync_m;     // first synchroniser stage
        logic [3:0]             sync_q;     // second synchroniser stage
        angle_map_pkg::supply_e supply;     // supply monitor state
        logic [11:0]            sup_cnt;    // supply dwell counter
        logic [19:0]            wd_cnt;     // cycles since heartbeat
        logic                   wd_fail;    // watchdog alarm
        angle_map_pkg::cfg_s    shadow;     // active settings
        angle_map_pkg::cfg_s    fuse;       // blown fuse bits
        logic                   loaded;     // shadow taken from fuses
        logic [7:0]             pre_cnt;    // pwm step prescaler
        logic [11:0]            pwm_cnt;    // position in period
        logic [11:0]            duty;       // code of this period
        logic [11:0]            duty_calc;  // mapped code, registered
        logic                   pwm_oe;     // pin pulled low
        logic [31:0]            prdata;     // read data
        logic                   pready;     // bus answer
        logic                   pslverr;    // bus error
    } state_s;

    state_s s_reg;       // registered state
    state_s s_next;      // next state

    // wide wdog count kept in 20 bits
    localparam logic [19:0] WD_LIMIT = 20'(WDOG_CYCLES);

    // =================================================================
    // next state logic
    always_comb begin
        logic [13:0]        a_rel;     // angle past break point
        logic [13:0]        t1_rel;    // start past break point
        logic [13:0]        t2_rel;    // stop past break point
        logic [16:0]        a_mul;     // replicated angle, wide
        logic [13:0]        a_rep;     // replicated angle
        logic signed [15:0] da;        // angle minus start
        logic signed [15:0] dt;        // stop minus start
        logic signed [12:0] dy;        // stop duty minus start duty
        logic signed [28:0] prod;      // da times dy
        logic signed [28:0] quot;      // interpolated offset
        logic signed [29:0] y;         // raw output code
        logic [11:0]        lo12;      // low clamp in duty units
        logic [11:0]        hi12;      // high clamp in duty units
        logic [11:0]        mapped;    // clamped code
        logic               alarm;     // internal alarm
        logic               enable;    // output stage allowed
        logic               tick;      // one pwm step
        logic               wr;        // bus write accepted
        logic               acc;       // bus access completing
        angle_map_pkg::cfg_s c;        // settings in use

        s_next = s_reg;
        a_rel  = '0;
        t1_rel = '0;
        t2_rel = '0;
        a_mul  = '0;
        a_rep  = '0;
        da     = '0;
        dt     = '0;
        dy     = '0;
        prod   = '0;
        quot   = '0;
        y      = '0;
        c      = s_reg.shadow;
        lo12 = '0;
        hi12 = '0;
        mapped = '0;
        alarm = '0;
        enable = '0;
        tick = '0;
        wr = '0;
        acc = '0;

        // supply comparator synchronisers
        s_next.sync_m = {uv_above_high, uv_below_low, ov_below_low, ov_above_high};
        s_next.sync_q = s_reg.sync_m;

        // -------------------------------------------------------------
        // supply monitor
        case (s_reg.supply)
            angle_map_pkg::SUPPLY_OK: begin
                if (s_reg.sync_q[0] || s_reg.sync_q[2]) begin
                    s_next.sup_cnt = s_reg.sup_cnt + 12'h001;
                    if (s_reg.sup_cnt >= angle_map_pkg::DET_CYC) begin
                        s_next.sup_cnt = '0;
                        // overvoltage takes priority
                        if (s_reg.sync_q[0]) begin
                            s_next.supply = angle_map_pkg::SUPPLY_OV;
                        end else begin
                            s_next.supply = angle_map_pkg::SUPPLY_UV;
                        end
                    end
                end else begin
                    s_next.sup_cnt = '0;
                end
            end
            angle_map_pkg::SUPPLY_OV: begin
                if (s_reg.sync_q[1]) begin
                    s_next.sup_cnt = s_reg.sup_cnt + 12'h001;
                    if (s_reg.sup_cnt >= angle_map_pkg::REC_CYC) begin
                        s_next.sup_cnt = '0;
                        s_next.supply  = angle_map_pkg::SUPPLY_OK;
                    end
                end else begin
                    s_next.sup_cnt = '0;
                end
            end
            angle_map_pkg::SUPPLY_UV: begin
                if (s_reg.sync_q[3]) begin
                    s_next.sup_cnt = s_reg.sup_cnt + 12'h001;
                    if (s_reg.sup_cnt >= angle_map_pkg::DET_CYC) begin
                        s_next.sup_cnt = '0;
                        s_next.supply  = angle_map_pkg::SUPPLY_OK;
                    end
                end else begin
                    s_next.sup_cnt = '0;
                end
            end
            default: begin
                s_next.supply  = angle_map_pkg::SUPPLY_OK;
                s_next.sup_cnt = '0;
            end
        endcase

        // -------------------------------------------------------------
        // watchdog on the processing heartbeat
        if (dsp_alive) begin
            s_next.wd_cnt = '0;
        end else if (s_reg.wd_cnt != WD_LIMIT) begin
            s_next.wd_cnt = s_reg.wd_cnt + 20'h00001;
        end
        s_next.wd_fail = (s_next.wd_cnt == WD_LIMIT);
        alarm = s_reg.wd_fail | mag_range_alarm | cordic_overflow | osc_fail;

        // -------------------------------------------------------------
        // angle mapping, everything relative to the break point
        a_rel  = angle_code - c.wrap_transition_point;
        t1_rel = c.angle_start_point - c.wrap_transition_point;
        t2_rel = c.angle_stop_point - c.wrap_transition_point;
        // copies of the reference slope over one turn
        a_mul  = a_rel * ({1'b0, c.slope_count_select} + 3'h1);
        a_rep  = a_mul[13:0];
        if (c.slope_invert) begin
            a_rep = ~a_rep;
        end
        da   = $signed({2'b00, a_rep}) - $signed({2'b00, t1_rel});
        dt   = $signed({2'b00, t2_rel}) - $signed({2'b00, t1_rel});
        dy   = $signed({1'b0, c.stop_duty_level}) - $signed({1'b0, c.start_duty_level});
        prod = da * dy;
        // a zero-width range holds the start duty
        if (dt != 16'sh0000) begin
            quot = prod / dt;
        end
        y = $signed({18'h00000, c.start_duty_level}) + quot;
        lo12 = {c.clamp_low_level, 3'h0};
        hi12 = {c.clamp_high_level, 3'h0};
        // clamps bound the slope; the wrap sits at the break point
        if (y < $signed({18'h00000, lo12})) begin
            mapped = lo12;
        end else if (y > $signed({18'h00000, hi12})) begin
            mapped = hi12;
        end else begin
            mapped = y[11:0];
        end
        // internal alarms replace the code by a fault band
        if (alarm) begin
            mapped = c.fault_band_polarity ? angle_map_pkg::FAULT_HIGH_DUTY
                                           : angle_map_pkg::FAULT_LOW_DUTY;
        end
        s_next.duty_calc = mapped;

        // -------------------------------------------------------------
        // pwm engine
        tick = (s_reg.pre_cnt >= angle_map_pkg::PWM_DIV[c.frame_rate_select] - 8'h01);
        if (tick) begin
            s_next.pre_cnt = '0;
            s_next.pwm_cnt = s_reg.pwm_cnt + 12'h001;
            // new code only at the end of a period
            if (s_reg.pwm_cnt == 12'hfff) begin
                s_next.duty = s_reg.duty_calc;
            end
        end else begin
            s_next.pre_cnt = s_reg.pre_cnt + 8'h01;
        end
        // supply faults and an unlocked part leave the pin released
        enable = s_reg.fuse.customer_lock_fuse
                 && (s_reg.supply == angle_map_pkg::SUPPLY_OK);
        // high for duty/4096 of the period, pulled low after
        s_next.pwm_oe = enable && (s_reg.pwm_cnt >= s_reg.duty);

        // -------------------------------------------------------------
        // shadow takes the fuse image once after reset
        if (!s_reg.loaded) begin
            s_next.shadow = s_reg.fuse;
            s_next.loaded = 1'b1;
        end

        // -------------------------------------------------------------
        // apb slave, one wait state
        acc = psel && penable && s_reg.pready;
        wr  = acc && pwrite && !s_reg.fuse.customer_lock_fuse;
        s_next.pready  = psel && penable && !s_reg.pready;
        s_next.pslverr = 1'b0;
        s_next.prdata  = '0;
        if (psel && penable && !s_reg.pready) begin
            case (paddr)
                angle_map_pkg::ADDR_RANGE: begin
                    s_next.prdata = {2'h0, c.angle_stop_point, 2'h0, c.angle_start_point};
                end
                angle_map_pkg::ADDR_DUTY: begin
                    s_next.prdata = {4'h0, c.stop_duty_level, 4'h0, c.start_duty_level};
                end
                angle_map_pkg::ADDR_CLAMP: begin
                    s_next.prdata = {7'h00, c.clamp_high_level, 7'h00, c.clamp_low_level};
                end
                angle_map_pkg::ADDR_MODE: begin
                    s_next.prdata = {7'h00, c.fault_band_polarity, 1'b0, c.frame_rate_select,
                                     c.slope_count_select, 1'b0, c.slope_invert, 2'h0,
                                     c.wrap_transition_point};
                end
                angle_map_pkg::ADDR_FUSE: begin
                    s_next.prdata = {31'h00000000, s_reg.fuse.customer_lock_fuse};
                end
                angle_map_pkg::ADDR_STATUS: begin
                    s_next.prdata = {4'h0, s_reg.duty, 10'h000, enable, alarm,
                                     s_reg.wd_fail, s_reg.supply, s_reg.loaded};
                end
                default: begin
                    s_next.pslverr = 1'b1;
                end
            endcase
            // locked parts refuse every write
            if (pwrite && (s_reg.fuse.customer_lock_fuse
                           || paddr == angle_map_pkg::ADDR_STATUS)) begin
                s_next.pslverr = 1'b1;
            end
            if (pwrite) begin
                s_next.prdata = '0;
            end
        end
        // settings may be rewritten at any time until locked
        if (wr) begin
            case (paddr)
                angle_map_pkg::ADDR_RANGE: begin
                    s_next.shadow.angle_start_point = pwdata[13:0];
                    s_next.shadow.angle_stop_point  = pwdata[29:16];
                end
                angle_map_pkg::ADDR_DUTY: begin
                    s_next.shadow.start_duty_level = pwdata[11:0];
                    s_next.shadow.stop_duty_level  = pwdata[27:16];
                end
                angle_map_pkg::ADDR_CLAMP: begin
                    s_next.shadow.clamp_low_level  = pwdata[8:0];
                    s_next.shadow.clamp_high_level = pwdata[24:16];
                end
                angle_map_pkg::ADDR_MODE: begin
                    s_next.shadow.wrap_transition_point = pwdata[13:0];
                    s_next.shadow.slope_invert          = pwdata[16];
                    s_next.shadow.slope_count_select    = pwdata[19:18];
                    s_next.shadow.frame_rate_select     = pwdata[22:20];
                    s_next.shadow.fault_band_polarity   = pwdata[24];
                end
                angle_map_pkg::ADDR_FUSE: begin
                    // fuses only blow; bit 0 burns, bit 1 burns and locks
                    if (pwdata[0] || pwdata[1]) begin
                        s_next.fuse = s_reg.fuse | s_reg.shadow;
                        s_next.fuse.customer_lock_fuse = pwdata[1];
                        s_next.shadow.customer_lock_fuse = pwdata[1];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // =================================================================
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // =================================================================
    // outputs straight from flip-flops
    assign prdata  = s_reg.prdata;
    assign pready  = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign pwm_oe  = s_reg.pwm_oe;
    assign pwm_o   = s_reg.loaded & 1'b0;

endmodule

// >>> bench/angle_map_sva.sv
// concurrent checks on the ports of the angle to pwm output mapper
`timescale 1ns/1ps
module angle_map_sva (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        ov_above_high,
    input wire logic        uv_below_low,
    input wire logic        pwm_o,
    input wire logic        pwm_oe
);
    // =================================================================
    // saturating counts of how long each supply fault input has been held
    localparam logic [11:0] LATE = angle_map_pkg::DET_CYC + 12'h00a; // detect time plus sync slack
    logic [11:0] ov_cnt_reg;  // cycles above the overvoltage threshold
    logic [11:0] uv_cnt_reg;  // cycles below the undervoltage threshold
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ov_cnt_reg <= 12'h000;
            uv_cnt_reg <= 12'h000;
        end else begin
            ov_cnt_reg <= !ov_above_high ? 12'h000 : ov_cnt_reg + 12'(ov_cnt_reg != 12'hfff);
            uv_cnt_reg <= !uv_below_low ? 12'h000 : uv_cnt_reg + 12'(uv_cnt_reg != 12'hfff);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // =================================================================
    // bus handshake and pin behaviour
    sequence access_s; psel && penable && !pready; endsequence
    sequence answer_s; pready ##1 !pready; endsequence
    wait_state_a: assert property (access_s |=> answer_s)
        else $error("bus answer not one cycle after access");
    idle_quiet_a: assert property (!psel |=> !pready && !pslverr)
        else $error("bus answer without a request");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside an answer");
    error_ready_a: assert property (pslverr |-> pready)
        else $error("error flag without an answer");
    pin_low_a: assert property (pwm_o == 1'b0)
        else $error("open drain data not low");
    ov_off_a: assert property (ov_cnt_reg > LATE |-> !pwm_oe)
        else $error("output still driven in overvoltage");
    uv_off_a: assert property (uv_cnt_reg > LATE |-> !pwm_oe)
        else $error("output still driven in undervoltage");
    release_min_a: assert property ($fell(pwm_oe) |-> !pwm_oe [*4])
        else $error("released phase shorter than one step");
endmodule
bind angle_to_pwm_output_mapper angle_map_sva u_angle_map_sva (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ov_above_high(ov_above_high),
    .uv_below_low(uv_below_low), .pwm_o(pwm_o), .pwm_oe(pwm_oe));

// >>> bench/pwm_line_reader.sv
// controller model that times the released phase of the open-drain pwm line
`timescale 1ns/1ps
module pwm_line_reader (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        pwm_o,
    input  wire logic        pwm_oe,
    input  wire logic        arm,
    output logic             meas_valid,
    output logic [31:0]      meas_high
);
    logic line;      // wire level, pulled up unless the device sinks it
    logic line_q;    // wire level one clock ago
    logic armed;     // waiting for the next released phase
    logic counting;  // inside a released phase
    assign line = pwm_oe ? pwm_o : 1'b1;
    // =================================================================
    // time one whole released phase after each arm request
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_q <= 1'b1;
            armed <= 1'b0;
            counting <= 1'b0;
            meas_valid <= 1'b0;
            meas_high <= 32'h0;
        end else begin
            line_q <= line;
            meas_valid <= 1'b0;
            if (arm) begin
                armed <= 1'b1;
            end
            if (armed && line && !line_q) begin
                counting <= 1'b1;
                meas_high <= 32'h1;
            end else if (counting && line) begin
                meas_high <= meas_high + 32'h1;
            end else if (counting) begin
                counting <= 1'b0;
                armed <= 1'b0;
                meas_valid <= 1'b1;
            end
        end
    end
endmodule

// >>> bench/tb_angle_to_pwm_output_mapper.sv
// self-checking testbench of the angle to pwm output mapper
`timescale 1ns/1ps
module tb_angle_to_pwm_output_mapper;
    // =================================================================
    // signals, expectation queues and counters
    localparam int PER = 4096 * int'(angle_map_pkg::PWM_DIV[0]); // cycles in one period
    localparam int DET = int'(angle_map_pkg::DET_CYC);            // supply filter cycles
    typedef struct {logic err; logic [31:0] data; logic [31:0] mask;} note_s;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, pwm_o, pwm_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, meas_high;
    logic [13:0] angle_code, ang;
    logic        dsp_alive, mag_range_alarm, cordic_overflow, osc_fail, hb_en, arm, meas_valid;
    logic        ov_above_high, ov_below_low, uv_below_low, uv_above_high;
    logic [11:0] d;
    note_s       apb_q[$];
    note_s       note;
    logic [31:0] hi_q[$];
    int          mismatches, n_compared, cyc, seed;
    logic [11:0] cfg_a [5] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h00c};
    logic [31:0] cfg_v [5] = '{32'h3000_1000, 32'h0e00_0200, 32'h01e0_0020, 32'h017d_2a5c, 32'h0};
    logic [31:0] cfg_m [5] = '{32'h3fff_3fff, 32'h0fff_0fff, 32'h01ff_01ff, 32'h017d_3fff,
                               32'h017d_3fff};
    angle_to_pwm_output_mapper #(.WDOG_CYCLES(200)) u_angle_to_pwm_output_mapper (
        .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .angle_code(angle_code), .dsp_alive(dsp_alive), .mag_range_alarm(mag_range_alarm),
        .cordic_overflow(cordic_overflow), .osc_fail(osc_fail), .ov_above_high(ov_above_high),
        .ov_below_low(ov_below_low), .uv_below_low(uv_below_low),
        .uv_above_high(uv_above_high), .pwm_o(pwm_o), .pwm_oe(pwm_oe));
    pwm_line_reader u_pwm_line_reader (.clk(clk), .rst_n(rst_n), .pwm_o(pwm_o),
        .pwm_oe(pwm_oe), .arm(arm), .meas_valid(meas_valid), .meas_high(meas_high));
    // =================================================================
    // clock, heartbeat and hang guard
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        dsp_alive <= hb_en && (cyc % 50 == 0);
        if (cyc == 120000) begin
            mismatches++;
            conclude();
        end
    end
    // =================================================================
    // compare, bus and closing tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] v,
                       input logic e, input logic [31:0] x, input logic [31:0] m);
        apb_q.push_back('{e, x, m});
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= v;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic e);
        apb(a, 1'b1, v, e, 32'h0, 32'hffff_ffff);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
        apb(a, 1'b0, 32'h0, 1'b0, x, m);
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task automatic map_check(input logic [13:0] a, input logic [31:0] mode, input logic [11:0] y);
        angle_code <= a;
        wr(12'h00c, mode, 1'b0);
        repeat (PER + 20) @(posedge clk);
        rd(12'h014, {4'h0, y, 16'h0}, 32'h0fff_0000);
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // =================================================================
    // watcher: oldest note against each bus answer and each pin timing
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            note = apb_q.pop_front();
            check({31'h0, pslverr}, {31'h0, note.err});
            check(prdata & note.mask, note.data);
        end
        if (meas_valid === 1'b1) begin
            check(meas_high, hi_q.pop_front());
        end
    end
    // =================================================================
    // main sequence
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, angle_code, arm, cyc} = '0;
        {dsp_alive, mag_range_alarm, cordic_overflow, osc_fail, ov_above_high, uv_below_low} = '0;
        {ov_below_low, uv_above_high, hb_en} = 3'b111;
        seed = 89312;
        do_reset();
        rd(12'h014, 32'h1, 32'h1);
        wr(12'h000, 32'h3000_1000, 1'b0);
        do_reset();
        rd(12'h000, 32'h0, 32'hffff_ffff);
        for (int i = 0; i < 5; i++) begin
            wr(cfg_a[i], cfg_v[i], 1'b0);
            rd(cfg_a[i], cfg_v[i] & cfg_m[i], cfg_m[i]);
        end
        apb(12'h020, 1'b0, 32'h0, 1'b1, 32'h0, 32'hffff_ffff);
        apb(12'h014, 1'b1, 32'h0, 1'b1, 32'h0, 32'hffff_ffff);
        $display("test registers done");
        map_check(14'h0800, 32'h0, 12'h100);
        map_check(14'h11ff, 32'h000d_0800, 12'h801);
        for (int i = 0; i < 3; i++) begin
            {osc_fail, cordic_overflow, mag_range_alarm} <= 3'b001 << i;
            repeat (4) @(posedge clk);
            rd(12'h014, 32'h10, 32'h10);
        end
        map_check(14'h2000, 32'h0100_0000, 12'hfae);
        osc_fail <= 1'b0;
        hb_en <= 1'b0;
        repeat (260) @(posedge clk);
        rd(12'h014, 32'h18, 32'h18);
        hb_en <= 1'b1;
        repeat (60) @(posedge clk);
        rd(12'h014, 32'h0, 32'h18);
        $display("test mapping and alarms done");
        wr(12'h00c, 32'h0, 1'b0);
        wr(12'h010, 32'h2, 1'b0);
        rd(12'h010, 32'h1, 32'h1);
        wr(12'h000, 32'h0, 1'b1);
        rd(12'h000, 32'h3000_1000, 32'h3fff_3fff);
        ang = 14'h1000 + 14'($random(seed) & 32'h1fff);
        d = 12'h200 + 12'(((32'(ang) - 32'h1000) * 3) >> 3);
        angle_code <= ang;
        repeat (PER + 20) @(posedge clk);
        rd(12'h014, {4'h0, d, 16'h20}, 32'h0fff_0020);
        hi_q.push_back(32'(d) * 32'(angle_map_pkg::PWM_DIV[0]));
        arm <= 1'b1;
        @(posedge clk);
        arm <= 1'b0;
        while (hi_q.size() != 0) @(posedge clk);
        $display("test locked output done");
        {ov_above_high, ov_below_low} <= 2'b10;
        repeat (DET + 60) @(posedge clk);
        rd(12'h014, 32'h2, 32'h26);
        {ov_above_high, ov_below_low} <= 2'b01;
        repeat (DET + 60) @(posedge clk);
        rd(12'h014, 32'h20, 32'h26);
        {uv_below_low, uv_above_high} <= 2'b10;
        repeat (1000) @(posedge clk);
        rd(12'h014, 32'h20, 32'h26);
        repeat (1100) @(posedge clk);
        rd(12'h014, 32'h4, 32'h26);
        {uv_below_low, uv_above_high} <= 2'b01;
        repeat (DET + 60) @(posedge clk);
        rd(12'h014, 32'h20, 32'h26);
        $display("test supply monitor done");
        conclude();
    end
endmodule
